// ===== spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// doze mode field encodings
`define SPM_MODE_IDLE      3'h0
`define SPM_MODE_NOISE     3'h1
`define SPM_MODE_STOP      3'h2
`define SPM_MODE_SAVE      3'h3
`define SPM_MODE_STANDBY   3'h6

// control register layout (doze arm in bit 0, mode field in bits 3:1)
`define SPM_ADDR_CTRL      8'h00
`define SPM_ADDR_STOP      8'h01
`define SPM_ADDR_STATUS    8'h02
`define SPM_ARM_BIT        0
`define SPM_MODE_LSB       1
`define SPM_CTRL_RESET     8'h00
`define SPM_STOP_RESET     8'h00

// wake timing, in cycles, and wake counter width in bits
`define SPM_STANDBY_WAKE   6
`define SPM_IRQ_HALT       4
`define SPM_CNT_W          16

`endif

// ===== spm_pkg.sv
package spm_pkg;
	typedef enum logic [5:0] {
		SPM_RUN      = 6'b00_0001,
		SPM_SLEEP    = 6'b00_0010,
		SPM_START    = 6'b00_0100,
		SPM_HALT     = 6'b00_1000,
		SPM_RESUME   = 6'b01_0000,
		SPM_SPARE    = 6'b10_0000
	} spm_state_e;

	typedef struct packed {
		logic       timer_ovf;
		logic       timer_cmp;
		logic       mask_ovf;
		logic       mask_cmp;
		logic       global_ie;
		logic       timer_on;
		logic       timer_async;
	} spm_timer_s;

	typedef struct packed {
		logic       adc_on;
		logic       comp_on;
		logic       bod_on;
	} spm_analog_s;
endpackage

// ===== spm_clk_gate.sv
`timescale 1ns/1ns
// latch-free gate: enable is retimed on the falling edge so the gate only
// opens or closes while the source clock is low
module spm_clk_gate (
	input  wire logic i_clk,
	input  wire logic i_en,
	output logic      o_gclk
);
	logic en_low_reg;

	always_ff @(negedge i_clk) begin
		en_low_reg <= i_en;
	end

	assign o_gclk = i_clk & en_low_reg;
endmodule

// ===== spm_sleep_power_manager.sv
`timescale 1ns/1ns
`include "spm_consts.svh"

// Behaviour
// - after stop-mode wake, wait the fuse-selected start-up delay before resuming.
// - mode 011 plus doze enters save mode, like stop except timer two.
// - in save mode an enabled timer two keeps its clock.
// - timer two overflow/compare wakes save mode if masked in and global enable set.
// - save mode stops timer oscillator unless timer two runs asynchronously.
// - save mode stops main clock unless timer two runs synchronously.
// - a main clock kept in save mode reaches only timer two.
// - mode 110 with crystal option enters standby; oscillator keeps running.
// - standby wake takes six oscillator cycles.
// - each clock-stop bit gates its own module clock independently.
// - stopped module is frozen and ignores register accesses.
// - clearing a stop bit resumes the module in its held state.
// - per-module stopping matters only in active and idle.
// - an enabled converter stays enabled in every sleep mode.
// - first conversion after converter re-enable is extended.
// - comparator is forced off in sleep modes other than idle and noise.
// - fuse-enabled brown-out detector stays on in every sleep mode.
// - reference is on exactly when brown-out, comparator or converter needs it.
// - sleep only when arm bit set and doze executes; otherwise no effect.
// - idle 000, noise 001, stop 010; 100, 101, 111 reserved.
// - interrupt wake halts four cycles beyond start-up, then resumes.
module spm_sleep_power_manager #(
	parameter int NMOD = 4
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [7:0]        o_rdata,
	input  wire logic              i_doze,
	input  wire logic              i_wake_irq,
	input  wire logic              i_wake_reset,
	input  wire logic [`SPM_CNT_W-1:0] i_startup_cycles,
	input  wire logic              i_crystal_option,
	input  wire spm_pkg::spm_timer_s  i_timer,
	input  wire spm_pkg::spm_analog_s i_analog,
	input  wire logic [NMOD-1:0]   i_mod_access,
	output logic [NMOD-1:0]        o_mod_access_ok,
	output logic [NMOD-1:0]        o_mod_clk,
	output logic                   o_cpu_clk,
	output logic                   o_io_clk,
	output logic                   o_adc_clk,
	output logic                   o_timer2_clk_en,
	output logic                   o_main_osc_en,
	output logic                   o_timer_osc_en,
	output logic                   o_cpu_halted,
	output logic                   o_run_isr,
	output logic                   o_adc_en,
	output logic                   o_adc_extended,
	output logic                   o_comp_en,
	output logic                   o_bod_en,
	output logic                   o_vref_en,
	output logic [2:0]             o_mode
);
	import spm_pkg::*;

	logic [7:0]        ctrl_reg;
	logic [NMOD-1:0]   stop_reg;
	spm_state_e        state_reg;
	spm_state_e        state_next;
	logic [2:0]        mode_reg;
	logic [`SPM_CNT_W-1:0] cnt_reg;
	logic              irq_wake_reg;
	logic              adc_prev_reg;
	logic              adc_ext_reg;
	logic [7:0]        rdata_reg;

	logic [2:0]        field;
	logic              arm;
	logic              timer_wake;
	logic              wake;
	logic              sleeping;
	logic              cpu_on;
	logic              io_on;
	logic              adc_clk_on;
	logic              save_mode;

	// reserved codes and standby without crystal collapse onto stop mode
	function automatic logic [2:0] spm_eff_mode(input logic [2:0] m, input logic xtal);
		logic [2:0] r;
		r = m;
		case (m)
			`SPM_MODE_IDLE, `SPM_MODE_NOISE, `SPM_MODE_STOP, `SPM_MODE_SAVE: r = m;
			`SPM_MODE_STANDBY: r = xtal ? m : `SPM_MODE_STOP;
			default: r = `SPM_MODE_STOP;
		endcase
		return r;
	endfunction

	assign field = ctrl_reg[`SPM_MODE_LSB +: 3];
	assign arm   = ctrl_reg[`SPM_ARM_BIT];

	// register file
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg <= `SPM_CTRL_RESET;
		end else if (i_wr && i_addr == `SPM_ADDR_CTRL) begin
			ctrl_reg <= {4'h0, i_wdata[3:0]};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			stop_reg <= NMOD'(`SPM_STOP_RESET);
		end else if (i_wr && i_addr == `SPM_ADDR_STOP) begin
			stop_reg <= i_wdata[NMOD-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				`SPM_ADDR_CTRL:   rdata_reg <= ctrl_reg;
				`SPM_ADDR_STOP:   rdata_reg <= 8'(stop_reg);
				`SPM_ADDR_STATUS: rdata_reg <= {2'h0, state_reg};
				default:          rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign o_rdata = rdata_reg;

	// wake sources
	assign save_mode  = (state_reg == SPM_SLEEP) && (mode_reg == `SPM_MODE_SAVE);
	assign timer_wake = save_mode && i_timer.global_ie &&
		((i_timer.timer_ovf && i_timer.mask_ovf) ||
		 (i_timer.timer_cmp && i_timer.mask_cmp));
	assign wake = i_wake_irq || i_wake_reset || timer_wake;

	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SPM_RUN: begin
				if (i_doze && arm) begin
					state_next = SPM_SLEEP;
				end
			end
			SPM_SLEEP: begin
				if (wake) begin
					state_next = SPM_START;
				end
			end
			SPM_START: begin
				if (cnt_reg == '0) begin
					state_next = irq_wake_reg ? SPM_HALT : SPM_RESUME;
				end
			end
			SPM_HALT: begin
				if (cnt_reg == '0) begin
					state_next = SPM_RESUME;
				end
			end
			SPM_RESUME: state_next = SPM_RUN;
			default:    state_next = SPM_RUN;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= SPM_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_reg <= `SPM_MODE_IDLE;
		end else if (state_reg == SPM_RUN && i_doze && arm) begin
			mode_reg <= spm_eff_mode(field, i_crystal_option);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_wake_reg <= 1'b0;
		end else if (state_reg == SPM_SLEEP && wake) begin
			irq_wake_reg <= !i_wake_reset && (i_wake_irq || timer_wake);
		end
	end

	// start-up delay: fuse-derived for deep modes, six cycles from standby
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_reg <= '0;
		end else if (state_reg == SPM_SLEEP && wake) begin
			if (mode_reg == `SPM_MODE_STANDBY) begin
				cnt_reg <= `SPM_CNT_W'(`SPM_STANDBY_WAKE - 1);
			end else if (mode_reg == `SPM_MODE_IDLE || mode_reg == `SPM_MODE_NOISE) begin
				cnt_reg <= '0;
			end else begin
				cnt_reg <= (i_startup_cycles == '0) ? '0 :
					i_startup_cycles - `SPM_CNT_W'(1);
			end
		end else if (state_reg == SPM_START && cnt_reg == '0) begin
			cnt_reg <= `SPM_CNT_W'(`SPM_IRQ_HALT - 1);
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - `SPM_CNT_W'(1);
		end
	end

	assign sleeping     = (state_reg == SPM_SLEEP) || (state_reg == SPM_START);
	assign o_cpu_halted = (state_reg != SPM_RUN);
	assign o_run_isr    = (state_reg == SPM_RESUME) && irq_wake_reg;
	assign o_mode       = mode_reg;

	// clock domains per mode
	assign cpu_on     = !o_cpu_halted;
	assign io_on      = !sleeping || mode_reg == `SPM_MODE_IDLE;
	assign adc_clk_on = io_on || mode_reg == `SPM_MODE_NOISE;

	// oscillators: main clock stays for standby and synchronous timer two
	always_comb begin
		o_main_osc_en  = 1'b1;
		o_timer_osc_en = i_timer.timer_async;
		if (sleeping) begin
			case (mode_reg)
				`SPM_MODE_STOP: o_main_osc_en = 1'b0;
				`SPM_MODE_SAVE: o_main_osc_en = i_timer.timer_on && !i_timer.timer_async;
				`SPM_MODE_STANDBY: o_main_osc_en = 1'b1;
				default: o_main_osc_en = 1'b1;
			endcase
			if (mode_reg == `SPM_MODE_STOP || mode_reg == `SPM_MODE_STANDBY) begin
				o_timer_osc_en = 1'b0;
			end else if (mode_reg == `SPM_MODE_SAVE) begin
				o_timer_osc_en = i_timer.timer_on && i_timer.timer_async;
			end
		end
	end

	// timer two is the only consumer of the main clock in save mode
	assign o_timer2_clk_en = i_timer.timer_on &&
		(!sleeping || mode_reg != `SPM_MODE_STOP && mode_reg != `SPM_MODE_STANDBY);

	spm_clk_gate u_cpu_gate (
		.i_clk  (i_clk),
		.i_en   (cpu_on),
		.o_gclk (o_cpu_clk)
	);

	spm_clk_gate u_io_gate (
		.i_clk  (i_clk),
		.i_en   (io_on),
		.o_gclk (o_io_clk)
	);

	spm_clk_gate u_adc_gate (
		.i_clk  (i_clk),
		.i_en   (adc_clk_on),
		.o_gclk (o_adc_clk)
	);

	// module clocks: stop bits act in active and idle; deeper modes halt io
	genvar g;
	generate
		for (g = 0; g < NMOD; g++) begin : g_mod
			spm_clk_gate u_mod_gate (
				.i_clk  (i_clk),
				.i_en   (io_on && !stop_reg[g]),
				.o_gclk (o_mod_clk[g])
			);
			// frozen module refuses register traffic
			assign o_mod_access_ok[g] = i_mod_access[g] && !stop_reg[g];
		end
	endgenerate

	// converter and brown-out enables follow their own settings through every sleep mode; comparator only in idle and noise
	assign o_adc_en  = i_analog.adc_on;
	assign o_bod_en  = i_analog.bod_on;
	assign o_comp_en = i_analog.comp_on && (!sleeping ||
		mode_reg == `SPM_MODE_IDLE || mode_reg == `SPM_MODE_NOISE);
	assign o_vref_en = o_bod_en || o_comp_en || o_adc_en;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			adc_prev_reg <= 1'b0;
		end else begin
			adc_prev_reg <= i_analog.adc_on;
		end
	end

	// extended flag held until the converter clock has run one conversion start
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			adc_ext_reg <= 1'b1;
		end else if (i_analog.adc_on && !adc_prev_reg) begin
			adc_ext_reg <= 1'b1;
		end else if (i_analog.adc_on && adc_clk_on) begin
			adc_ext_reg <= 1'b0;
		end
	end
	assign o_adc_extended = adc_ext_reg && i_analog.adc_on;
endmodule

// ===== spm_chk.sv
`timescale 1ns/1ns
module spm_chk #(
	parameter int NMOD = 4
) (
	input wire logic                i_clk,
	input wire logic                i_rst,
	input wire logic [7:0]          i_addr,
	input wire logic [7:0]          i_wdata,
	input wire logic                i_wr,
	input wire logic                i_doze,
	input wire logic                i_crystal_option,
	input wire spm_pkg::spm_analog_s i_analog,
	input wire logic [NMOD-1:0]     i_mod_access,
	input wire logic [NMOD-1:0]     o_mod_access_ok,
	input wire logic [NMOD-1:0]     o_mod_clk,
	input wire logic                o_cpu_clk,
	input wire logic                o_io_clk,
	input wire logic                o_adc_clk,
	input wire logic                o_cpu_halted,
	input wire logic                o_run_isr,
	input wire logic                o_adc_en,
	input wire logic                o_comp_en,
	input wire logic                o_bod_en,
	input wire logic                o_vref_en,
	input wire logic [2:0]          o_mode
);
	import spm_pkg::*;
	logic [7:0]      ctrl_reg;
	logic [7:0]      stop_reg;
	logic [2:0]      eff_mode;
	logic [NMOD-1:0] stopped;
	assign stopped = stop_reg[NMOD-1:0];
	// shadow of the two writable registers, rebuilt from the bus
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg <= 8'h00;
			stop_reg <= 8'h00;
		end else if (i_wr) begin
			if (i_addr == 8'h00)
				ctrl_reg <= i_wdata;
			if (i_addr == 8'h01)
				stop_reg <= i_wdata;
		end
	end
	// reserved codes and standby without a crystal fall back to stop
	always_comb begin
		eff_mode = ctrl_reg[3:1];
		if (eff_mode[2] && (eff_mode != 3'h6 || !i_crystal_option))
			eff_mode = 3'h2;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_armed;
		i_doze && ctrl_reg[0] && !o_cpu_halted;
	endsequence
	sequence s_resume;
		o_run_isr && o_cpu_halted;
	endsequence
	a_doze_enters: assert property (s_armed |=> o_cpu_halted && o_mode == $past(eff_mode))
		else $error("doze did not enter the chosen mode");
	a_doze_refused: assert property (i_doze && !ctrl_reg[0] && !o_cpu_halted |=> !o_cpu_halted)
		else $error("unarmed doze slept");
	a_adc_kept: assert property (o_adc_en == i_analog.adc_on)
		else $error("converter enable lost");
	a_bod_kept: assert property (o_bod_en == i_analog.bod_on)
		else $error("brown-out enable lost");
	a_vref_need: assert property (o_vref_en == (o_adc_en || o_comp_en || o_bod_en))
		else $error("reference enable wrong");
	a_comp_run: assert property (!o_cpu_halted |-> o_comp_en == i_analog.comp_on)
		else $error("comparator wrong while running");
	a_access_gate: assert property (!o_cpu_halted |-> o_mod_access_ok == (i_mod_access & ~stopped))
		else $error("stopped module answered");
	a_gate_low: assert property (o_mod_clk == '0 && !o_cpu_clk && !o_io_clk && !o_adc_clk)
		else $error("gated clock high in low phase");
	a_isr_resume: assert property (o_run_isr |-> s_resume ##1 !o_cpu_halted)
		else $error("handler pulse outside resume");
	a_stop_gates: assert property (@(negedge i_clk) disable iff (i_rst) (o_mod_clk & stopped & $past(stopped)) == '0)
		else $error("stopped module clock ran");
	a_run_clocks: assert property (@(negedge i_clk) disable iff (i_rst)
		!o_cpu_halted && !$past(o_cpu_halted) && !$past(i_rst) |-> (o_mod_clk | stopped | $past(stopped)) == '1)
		else $error("running module clock missing");
endmodule

bind spm_sleep_power_manager spm_chk #(.NMOD(NMOD)) i_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
	.i_doze, .i_crystal_option, .i_analog, .i_mod_access, .o_mod_access_ok, .o_mod_clk, .o_cpu_clk,
	.o_io_clk, .o_adc_clk, .o_cpu_halted, .o_run_isr, .o_adc_en, .o_comp_en, .o_bod_en, .o_vref_en,
	.o_mode);

// ===== spm_periph_model.sv
`timescale 1ns/1ns
module spm_periph_model #(
	parameter int N = 4
) (
	input  wire logic [N-1:0] i_mod_clk,
	input  wire logic         i_rst,
	output logic [7:0]        o_state [N]
);
	// state moves only on its own gated clock, so a stop freezes it in place
	for (genvar k = 0; k < N; k++) begin : g_mod
		always_ff @(posedge i_mod_clk[k] or posedge i_rst) begin
			if (i_rst)
				o_state[k] <= 8'h00;
			else
				o_state[k] <= o_state[k] + 8'h01;
		end
	end
endmodule

// ===== spm_testbench.sv
`timescale 1ns/1ns
module testbench;
	import spm_pkg::*;
	localparam int SU = 10;
	logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_doze = 0;
	logic i_wake_irq = 0, i_wake_reset = 0, i_crystal_option = 1;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic [15:0] i_startup_cycles = 16'(SU);
	spm_timer_s i_timer = '0;
	// all analog users on; nothing here reads the reference output
	spm_analog_s i_analog = 3'h7;
	logic [3:0] i_mod_access = 4'hF, o_mod_access_ok, o_mod_clk;
	logic o_timer2_clk_en, o_main_osc_en, o_timer_osc_en, o_cpu_halted, o_run_isr;
	logic o_adc_extended, o_comp_en, isr;
	logic o_cpu_clk, o_io_clk, o_adc_clk;
	logic [2:0] o_mode;
	logic [7:0] st [4], c0 [4];
	logic [15:0] row;
	int num_errors = 0, check_count = 0, n;
	// nibbles: mode, {crystal, timer on, async, irq wake}, mode seen, {main, timer osc, t2 clk, 0}
	logic [15:0] rows [11] = '{16'h0_9_0_8, 16'h1_8_1_8, 16'h2_9_2_0, 16'h3_E_3_6, 16'h3_D_3_A,
		16'h3_8_3_0, 16'h4_8_2_0, 16'h5_9_2_0, 16'h7_8_2_0, 16'h6_9_6_8, 16'h6_0_2_0};
	spm_sleep_power_manager #(.NMOD(4)) i_dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_doze, .i_wake_irq, .i_wake_reset, .i_startup_cycles, .i_crystal_option,
		.i_timer, .i_analog, .i_mod_access, .o_mod_access_ok, .o_mod_clk, .o_cpu_clk,
		.o_io_clk, .o_adc_clk, .o_timer2_clk_en, .o_main_osc_en, .o_timer_osc_en,
		.o_cpu_halted, .o_run_isr, .o_adc_en(), .o_adc_extended, .o_comp_en, .o_bod_en(),
		.o_vref_en(), .o_mode);
	spm_periph_model #(.N(4)) i_periph (.i_mod_clk(o_mod_clk), .i_rst, .o_state(st));
	task check(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task tick(int k);
		repeat (k) @(posedge i_clk);
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		tick(1);
		i_wr <= 1'b0;
	endtask
	task rdc(string nm, logic [7:0] a, logic [7:0] exp);
		i_rd <= 1'b1;
		i_addr <= a;
		tick(1);
		i_rd <= 1'b0;
		tick(1);
		check(nm, o_rdata, exp);
	endtask
	task doze();
		i_doze <= 1'b1;
		tick(1);
		i_doze <= 1'b0;
	endtask
	// counts halted cycles from the edge that takes the wake request
	task wake(output int len, output logic seen);
		len = 0;
		seen = 0;
		tick(1);
		i_timer.timer_ovf <= 1'b0;
		i_timer.timer_cmp <= 1'b0;
		for (int k = 0; k < 60; k++) begin
			tick(1);
			seen |= o_run_isr;
			if (o_cpu_halted !== 1'b1) begin
				i_wake_irq <= 1'b0;
				i_wake_reset <= 1'b0;
				return;
			end
			len++;
		end
		num_errors++;
		results();
	endtask
	function int wlen(logic [2:0] m, logic irq);
		wlen = (m < 3'h2) ? 1 : (m == 3'h6) ? 6 : SU;
		if (irq)
			wlen += 4;
		// every wake ends with one resume cycle before the core runs again
		wlen += 1;
	endfunction
	initial begin
		forever #20 i_clk = ~i_clk;
	end
	initial begin
		tick(2);
		i_rst <= 1'b0;
		tick(1);
		for (int r = 0; r < 11; r++) begin
			row = rows[r];
			i_crystal_option <= row[11];
			i_timer.timer_on <= row[10];
			i_timer.timer_async <= row[9];
			wr(8'h00, {4'h0, row[14:12], 1'b1});
			doze();
			tick(2);
			c0 = st;
			check("mode", o_mode, row[6:4]);
			check("main_osc", o_main_osc_en, row[3]);
			check("timer_osc", o_timer_osc_en, row[2]);
			if (row[6:4] == 3'h3)
				check("t2_clk", o_timer2_clk_en, row[1]);
			check("comp", o_comp_en, row[6:4] < 3'h2);
			// look inside the high phase, where a running gated clock shows 1
			#5;
			check("cpu_clk", o_cpu_clk, 1'b0);
			check("io_clk", o_io_clk, row[6:4] == 3'h0);
			check("adc_clk", o_adc_clk, row[6:4] < 3'h2);
			tick(3);
			if (row[6:4] > 3'h1)
				check("frozen", st == c0, 1'b1);
			if (row[8])
				i_wake_irq <= 1'b1;
			else
				i_wake_reset <= 1'b1;
			wake(n, isr);
			check("wake_len", n, wlen(row[6:4], row[8]));
			check("isr", isr, row[8]);
		end
		i_rst <= 1'b1;
		tick(2);
		i_rst <= 1'b0;
		tick(1);
		check("extended", o_adc_extended, 1'b1);
		tick(2);
		check("ext_done", o_adc_extended, 1'b0);
		i_analog.adc_on <= 1'b0;
		tick(2);
		i_analog.adc_on <= 1'b1;
		tick(2);
		check("ext_again", o_adc_extended, 1'b1);
		rdc("ctrl", 8'h00, 8'h00);
		rdc("stop", 8'h01, 8'h00);
		wr(8'h02, 8'hFF);
		rdc("status", 8'h02, 8'h01);
		rdc("unmapped", 8'h03, 8'h00);
		wr(8'h00, 8'h04);
		doze();
		tick(2);
		check("unarmed", o_cpu_halted, 1'b0);
		// module 1 holds nothing, so it may be stopped at once
		wr(8'h01, 8'h02);
		tick(2);
		c0 = st;
		tick(4);
		check("held", st[1], c0[1]);
		check("other", 8'(st[0] - c0[0]), 4);
		check("access", o_mod_access_ok, 4'hD);
		wr(8'h01, 8'h00);
		tick(4);
		check("resume", st[1] > c0[1] && st[1] <= c0[1] + 5, 1'b1);
		i_timer <= '{timer_on: 1'b1, timer_async: 1'b1, global_ie: 1'b1, default: 1'b0};
		wr(8'h00, 8'h07);
		doze();
		tick(2);
		i_timer.timer_ovf <= 1'b1;
		tick(1);
		i_timer.timer_ovf <= 1'b0;
		i_timer.global_ie <= 1'b0;
		i_timer.mask_cmp <= 1'b1;
		tick(1);
		i_timer.timer_cmp <= 1'b1;
		tick(1);
		i_timer.timer_cmp <= 1'b0;
		tick(3);
		check("masked", o_cpu_halted, 1'b1);
		i_timer.global_ie <= 1'b1;
		i_timer.timer_cmp <= 1'b1;
		wake(n, isr);
		check("timer_wake", n, wlen(3'h3, 1'b1));
		results();
	end
endmodule
